// [amp_serial_config_registers.sv]
`timescale 1ns/1ps
`default_nettype none
`include "amp_cfg.svh"

module amp_serial_config_registers #(
	parameter logic [6:0] DEV_ADDR = `AMP_DEV_ADDR
) (
	input  wire logic                clk,
	input  wire logic                rst_n,
	input  wire logic                scl,
	input  wire logic                sda_in,
	output logic                     sda_out,
	output logic                     sda_oe,
	input  wire logic                combined_mode,
	input  wire logic                format_strap0,
	input  wire logic                format_strap1,
	input  wire logic                format_strap2,
	input  wire logic                clock_ratio_strap,
	input  wire logic                rate_band_strap,
	input  wire logic [1:0]          pin_ratio_code,
	input  wire logic [1:0]          pin_band_code,
	input  wire logic                rate_mismatch,
	output amp_pkg::serial_setting_t serial_setting,
	output amp_pkg::chan_ctrl_t      left_ctrl,
	output amp_pkg::chan_ctrl_t      right_ctrl,
	output amp_pkg::misc_t           modulator,
	output logic                     left_out_en,
	output logic                     right_out_en,
	output logic [7:0]               last_access
);
	import amp_pkg::*;

	// line sampling
	logic scl_q;
	logic sda_q;
	logic start_cond;
	logic stop_cond;
	logic scl_rise;
	logic scl_fall;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl;
			sda_q <= sda_in;
		end
	end

	always_comb begin
		start_cond = scl && scl_q && sda_q && !sda_in;
		stop_cond  = scl && scl_q && !sda_q && sda_in;
		scl_rise   = scl && !scl_q;
		scl_fall   = !scl && scl_q;
	end

	// register bank state
	input_cfg_t in_cfg;
	chan_ctrl_t left_reg;
	chan_ctrl_t right_reg;
	misc_t      misc_reg;
	logic [7:0] status_reg;
	input_cfg_t next_in_cfg;
	chan_ctrl_t next_left_reg;
	chan_ctrl_t next_right_reg;
	misc_t      next_misc_reg;
	logic [7:0] next_status_reg;

	// bus engine state
	bus_state_t state;
	logic [3:0] bit_cnt;
	logic [7:0] shift;
	logic [7:0] ptr;
	logic       oe;
	bus_state_t next_state;
	logic [3:0] next_bit_cnt;
	logic [7:0] next_shift;
	logic [7:0] next_ptr;
	logic       next_oe;
	logic       wr_en;
	logic       rd_load;
	logic [7:0] rd_value;

	function automatic logic [7:0] read_byte(
		input logic [7:0]  addr,
		input logic [7:0]  status,
		input input_cfg_t  cfg,
		input chan_ctrl_t  lch,
		input chan_ctrl_t  rch,
		input misc_t       misc
	);
		case (addr)
			`AMP_OFS_STATUS:    read_byte = status;
			`AMP_OFS_INPUT_CFG: read_byte = cfg;
			`AMP_OFS_LEFT:      read_byte = lch;
			`AMP_OFS_RIGHT:     read_byte = rch;
			`AMP_OFS_MISC:      read_byte = misc;
			default:            read_byte = 8'h00;
		endcase
	endfunction

	always_comb begin
		rd_value = read_byte(ptr, status_reg, in_cfg, left_reg, right_reg, misc_reg);
	end

	always_comb begin
		next_state   = state;
		next_bit_cnt = bit_cnt;
		next_shift   = shift;
		next_ptr     = ptr;
		next_oe      = oe;
		wr_en        = 1'b0;
		rd_load      = 1'b0;
		if (start_cond) begin
			// repeated start lands here too, keeping the pointer
			next_state   = BUS_DEV;
			next_bit_cnt = 4'h0;
			next_oe      = 1'b0;
		end else if (stop_cond) begin
			next_state = BUS_IDLE;
			next_oe    = 1'b0;
		end else begin
			case (state)
				BUS_IDLE: begin
					next_oe = 1'b0;
				end
				BUS_DEV, BUS_ADDR, BUS_WDATA: begin
					if (scl_rise) begin
						next_shift   = {shift[6:0], sda_in};
						next_bit_cnt = bit_cnt + 4'h1;
					end else if (scl_fall && bit_cnt == `AMP_BITS_PER_BYTE) begin
						next_oe = 1'b1;
						case (state)
							BUS_DEV: begin
								if (shift[7:1] == DEV_ADDR) begin
									next_state = BUS_DEV_ACK;
								end else begin
									// not ours: stay off the line until the next start
									next_state = BUS_IDLE;
									next_oe    = 1'b0;
								end
							end
							BUS_ADDR: next_state = BUS_ADDR_ACK;
							default:  next_state = BUS_WR_ACK;
						endcase
					end
				end
				BUS_DEV_ACK: begin
					if (scl_fall) begin
						next_bit_cnt = 4'h0;
						if (shift[0]) begin
							rd_load    = 1'b1;
							next_shift = rd_value;
							next_oe    = !rd_value[7];
							next_state = BUS_RDATA;
						end else begin
							next_oe    = 1'b0;
							next_state = BUS_ADDR;
						end
					end
				end
				BUS_ADDR_ACK: begin
					if (scl_fall) begin
						next_ptr     = shift;
						next_bit_cnt = 4'h0;
						next_oe      = 1'b0;
						next_state   = BUS_WDATA;
					end
				end
				BUS_WR_ACK: begin
					if (scl_fall) begin
						wr_en        = 1'b1;
						next_bit_cnt = 4'h0;
						next_oe      = 1'b0;
						next_state   = BUS_WDATA;
					end
				end
				BUS_RDATA: begin
					if (scl_rise) begin
						if (bit_cnt == `AMP_BITS_PER_BYTE) begin
							// master ack slot: a high level ends the read
							if (sda_in) begin
								next_state = BUS_IDLE;
							end else begin
								next_bit_cnt = 4'h9;
							end
						end else begin
							next_bit_cnt = bit_cnt + 4'h1;
						end
					end else if (scl_fall) begin
						if (bit_cnt == `AMP_BITS_PER_BYTE) begin
							// all eight bits out: let go for the master's ack
							next_oe = 1'b0;
						end else if (bit_cnt == 4'h9) begin
							rd_load      = 1'b1;
							next_shift   = rd_value;
							next_oe      = !rd_value[7];
							next_bit_cnt = 4'h0;
						end else begin
							next_shift = {shift[6:0], 1'b0};
							next_oe    = !shift[6];
						end
					end
				end
				default: begin
					next_state = BUS_IDLE;
					next_oe    = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state   <= BUS_IDLE;
			bit_cnt <= 4'h0;
			shift   <= 8'h00;
			ptr     <= 8'h00;
			oe      <= 1'b0;
		end else begin
			state   <= next_state;
			bit_cnt <= next_bit_cnt;
			shift   <= next_shift;
			ptr     <= next_ptr;
			oe      <= next_oe;
		end
	end

	always_comb begin
		next_in_cfg     = in_cfg;
		next_left_reg   = left_reg;
		next_right_reg  = right_reg;
		next_misc_reg   = misc_reg;
		next_status_reg = status_reg;
		if (wr_en || rd_load) begin
			next_status_reg = ptr;
		end
		if (wr_en) begin
			case (ptr)
				`AMP_OFS_INPUT_CFG: begin
					next_in_cfg = shift & `AMP_INPUT_CFG_MASK;
				end
				`AMP_OFS_LEFT: begin
					next_left_reg = shift;
				end
				`AMP_OFS_RIGHT: begin
					next_right_reg = shift;
				end
				`AMP_OFS_MISC: begin
					// reserved bits stay zero, bit 0 stays set
					next_misc_reg = (shift & `AMP_MISC_WR_MASK) | `AMP_MISC_FIXED;
				end
				`AMP_OFS_SOFT_RESET: begin
					if (shift == `AMP_INIT_CODE) begin
						next_in_cfg    = `AMP_RST_INPUT_CFG;
						next_left_reg  = `AMP_RST_CHAN;
						next_right_reg = `AMP_RST_CHAN;
						next_misc_reg  = `AMP_RST_MISC;
					end
				end
				default: begin
					next_in_cfg = in_cfg;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			in_cfg     <= `AMP_RST_INPUT_CFG;
			left_reg   <= `AMP_RST_CHAN;
			right_reg  <= `AMP_RST_CHAN;
			misc_reg   <= `AMP_RST_MISC;
			status_reg <= `AMP_RST_STATUS;
		end else begin
			in_cfg     <= next_in_cfg;
			left_reg   <= next_left_reg;
			right_reg  <= next_right_reg;
			misc_reg   <= next_misc_reg;
			status_reg <= next_status_reg;
		end
	end

	amp_setting_resolver u_resolver (
		.combined_mode     (combined_mode),
		.format_straps     ({format_strap2, format_strap1, format_strap0}),
		.clock_ratio_strap (clock_ratio_strap),
		.rate_band_strap   (rate_band_strap),
		.pin_ratio_code    (pin_ratio_code),
		.pin_band_code     (pin_band_code),
		.reg_cfg           (in_cfg),
		.setting           (serial_setting)
	);

	// open drain: only ever pull low
	assign sda_out = 1'b0;
	assign sda_oe  = oe;

	assign left_ctrl   = left_reg;
	assign right_ctrl  = right_reg;
	assign modulator   = misc_reg;
	assign last_access = status_reg;

	// a clock or rate mismatch silences both outputs rather than risk bad sound
	assign left_out_en  = !left_reg.pwm_stop && !rate_mismatch;
	assign right_out_en = !right_reg.pwm_stop && !rate_mismatch;

endmodule

`default_nettype wire

// [amp_cfg.svh]
// Behaviour
// - register 0x00 is read-only and shows the last register address accessed.
// - register 0x10 bits 2:0 hold the PCM format selector, reset 000; bit 7 is zero.
// - register 0x10 bits 4:3 select the sampling-rate band, reset 01.
// - register 0x10 bits 6:5 select the master clock ratio, reset 00.
// - registers 0x20 and 0x21 hold a 6-bit channel gain in bits 5:0, reset 0.
// - bit 6 of each channel register is active-low mute, reset 0 (muted).
// - bit 7 of each channel register stops that channel's PWM output, reset 0.
// - register 0x30 bit 0 is fixed 1; bit 1 is mute pulse control, reset 1.
// - register 0x30 bit 2 selects the modulation index, reset 0.
// - register 0x30 bit 3 selects noise shaper order, reset 0; upper bits reserved.
// - format codes 000, 001, 010 are I2S, left-justified, right-justified LSB-first.
// - codes 011 to 110 are right-justified MSB-first of 24, 20, 18, 16 bits.
// - register format applies only in combined mode with all format straps low.
// - register clock ratio applies only in combined mode with ratio strap low.
// - register rate band applies only in combined mode with rate strap low.
// - settings that do not match the input may switch the output off.
// - master clock ratio per band and code follows the fixed fs table.
// - serial input takes a 64 fs bit clock with 24-bit sample slots.
// - register 0xFF is an 8-bit register for initialising the others.
// - writing 0xFF to register 0xFF restores registers 0x10, 0x20, 0x21 and 0x30, not 0x00; it is write-only.
`ifndef AMP_CFG_SVH
`define AMP_CFG_SVH

`define AMP_DEV_ADDR        7'h6C
`define AMP_OFS_STATUS      8'h00
`define AMP_OFS_INPUT_CFG   8'h10
`define AMP_OFS_LEFT        8'h20
`define AMP_OFS_RIGHT       8'h21
`define AMP_OFS_MISC        8'h30
`define AMP_OFS_SOFT_RESET  8'hFF

`define AMP_RST_INPUT_CFG   8'h08
`define AMP_RST_CHAN        8'h00
`define AMP_RST_MISC        8'h03
`define AMP_RST_STATUS      8'h00
`define AMP_INIT_CODE       8'hFF

`define AMP_INPUT_CFG_MASK  8'h7F
`define AMP_MISC_WR_MASK    8'h0E
`define AMP_MISC_FIXED      8'h01

`define AMP_BITS_PER_BYTE   4'h8
`define AMP_BCLK_PER_FRAME  7'h40
`define AMP_SLOT_BITS       5'h18

`endif

// [amp_pkg.sv]
package amp_pkg;

	typedef enum logic [2:0] {
		FMT_I2S       = 3'b000,
		FMT_LEFT_MSB  = 3'b001,
		FMT_RIGHT_LSB = 3'b010,
		FMT_RIGHT_24  = 3'b011,
		FMT_RIGHT_20  = 3'b100,
		FMT_RIGHT_18  = 3'b101,
		FMT_RIGHT_16  = 3'b110,
		FMT_UNUSED    = 3'b111
	} pcm_format_t;

	typedef struct packed {
		logic       fixed_zero;
		logic [1:0] mclk_ratio_sel;
		logic [1:0] sample_band_sel;
		logic [2:0] pcm_format_sel;
	} input_cfg_t;

	typedef struct packed {
		logic       pwm_stop;
		logic       mute_n;
		logic [5:0] gain;
	} chan_ctrl_t;

	typedef struct packed {
		logic [3:0] reserved;
		logic       shaper_order_sel;
		logic       mod_index_sel;
		logic       mute_pulse_ctrl;
		logic       fixed_one;
	} misc_t;

	typedef struct packed {
		pcm_format_t format;
		logic [1:0]  band;
		logic [1:0]  ratio;
		logic [4:0]  word_bits;
		logic [9:0]  mclk_fs;
		logic [6:0]  bclk_fs;
	} serial_setting_t;

	typedef enum logic [2:0] {
		BUS_IDLE     = 3'b000,
		BUS_DEV      = 3'b001,
		BUS_DEV_ACK  = 3'b010,
		BUS_ADDR     = 3'b011,
		BUS_ADDR_ACK = 3'b100,
		BUS_WDATA    = 3'b101,
		BUS_WR_ACK   = 3'b110,
		BUS_RDATA    = 3'b111
	} bus_state_t;

endpackage

// [amp_setting_resolver.sv]
`timescale 1ns/1ps
`default_nettype none
`include "amp_cfg.svh"

module amp_setting_resolver (
	input  wire logic                      combined_mode,
	input  wire logic [2:0]                format_straps,
	input  wire logic                      clock_ratio_strap,
	input  wire logic                      rate_band_strap,
	input  wire logic [1:0]                pin_ratio_code,
	input  wire logic [1:0]                pin_band_code,
	input  wire amp_pkg::input_cfg_t       reg_cfg,
	output amp_pkg::serial_setting_t       setting
);
	import amp_pkg::*;

	function automatic logic reg_wins(input logic combined, input logic strap_high);
		reg_wins = combined && !strap_high;
	endfunction

	function automatic logic [9:0] ratio_fs(input logic [1:0] band, input logic [1:0] ratio);
		logic [9:0] base;
		base = 10'h000;
		case (ratio)
			2'b00: base = 10'h100;
			2'b01: base = 10'h180;
			2'b10: base = 10'h200;
			default: base = 10'h300;
		endcase
		case (band)
			2'b10: ratio_fs = base >> 1;
			2'b11: ratio_fs = base >> 2;
			default: ratio_fs = base;
		endcase
	endfunction

	logic [2:0] fmt_code;

	always_comb begin
		// straps steer the format unless all are low in combined mode
		fmt_code = reg_wins(combined_mode, |format_straps) ? reg_cfg.pcm_format_sel
			: format_straps;
		setting.format = pcm_format_t'(fmt_code);
		setting.ratio = reg_wins(combined_mode, clock_ratio_strap) ? reg_cfg.mclk_ratio_sel
			: pin_ratio_code;
		setting.band = reg_wins(combined_mode, rate_band_strap) ? reg_cfg.sample_band_sel
			: pin_band_code;
		setting.mclk_fs = ratio_fs(setting.band, setting.ratio);
		setting.bclk_fs = `AMP_BCLK_PER_FRAME;
		case (setting.format)
			FMT_RIGHT_20: setting.word_bits = 5'h14;
			FMT_RIGHT_18: setting.word_bits = 5'h12;
			FMT_RIGHT_16: setting.word_bits = 5'h10;
			default: setting.word_bits = `AMP_SLOT_BITS;
		endcase
	end

endmodule

`default_nettype wire

// [i2c_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
	input  wire logic clk,
	input  wire logic sda_line,
	output var logic  scl,
	output var logic  sda
);
	// half period in clk cycles; 2 is the fastest the device accepts
	int half = 2;
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	task automatic tick();
		repeat (half) @(posedge clk);
		#1;
	endtask
	// sda high means released; the pull-up gives the level
	task automatic start();
		sda = 1'b1;
		tick();
		scl = 1'b1;
		tick();
		sda = 1'b0;
		tick();
		scl = 1'b0;
	endtask
	task automatic bit_io(input logic b, output logic s);
		sda = b;
		tick();
		scl = 1'b1;
		tick();
		s = sda_line;
		scl = 1'b0;
	endtask
	task automatic put(input logic [7:0] d, output logic nak);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(d[i], s);
		bit_io(1'b1, nak);
	endtask
	task automatic get(input logic nak, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(nak, s);
	endtask
	task automatic stop();
		sda = 1'b0;
		tick();
		scl = 1'b1;
		tick();
		sda = 1'b1;
		tick();
	endtask
endmodule
`default_nettype wire

// [amp_serial_config_registers_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module amp_cfg_checker (
	input wire logic                     clk,
	input wire logic                     rst_n,
	input wire logic                     scl,
	input wire logic                     sda_oe,
	input wire logic                     combined_mode,
	input wire logic                     format_strap0,
	input wire logic                     format_strap1,
	input wire logic                     format_strap2,
	input wire logic                     clock_ratio_strap,
	input wire logic                     rate_band_strap,
	input wire logic [1:0]               pin_ratio_code,
	input wire logic [1:0]               pin_band_code,
	input wire logic                     rate_mismatch,
	input wire amp_pkg::serial_setting_t serial_setting,
	input wire amp_pkg::chan_ctrl_t      left_ctrl,
	input wire amp_pkg::chan_ctrl_t      right_ctrl,
	input wire amp_pkg::misc_t           modulator,
	input wire logic                     left_out_en,
	input wire logic                     right_out_en
);
	import amp_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	logic [2:0] straps;
	assign straps = {format_strap2, format_strap1, format_strap0};
	function automatic logic [9:0] mfs(input logic [1:0] b, input logic [1:0] r);
		logic [9:0] v;
		v = r[0] ? 10'h180 : 10'h100;
		if (r[1]) v = v << 1;
		return v >> (b[1] ? 2'(b[0]) + 2'h1 : 2'h0);
	endfunction
	a_misc_fixed: assert property (modulator.fixed_one && modulator.reserved == 4'h0)
		else $error("fixed bits of modulator wrong");
	a_out_enables: assert property (left_out_en == (!left_ctrl.pwm_stop && !rate_mismatch)
		&& right_out_en == (!right_ctrl.pwm_stop && !rate_mismatch))
		else $error("output enable wrong");
	a_pin_format: assert property ((!combined_mode || straps != 3'h0)
		|-> serial_setting.format == straps) else $error("format not from straps");
	a_pin_ratio: assert property ((!combined_mode || clock_ratio_strap)
		|-> serial_setting.ratio == pin_ratio_code) else $error("ratio not from pins");
	a_pin_band: assert property ((!combined_mode || rate_band_strap)
		|-> serial_setting.band == pin_band_code) else $error("band not from pins");
	a_clock_table: assert property (serial_setting.mclk_fs
		== mfs(serial_setting.band, serial_setting.ratio)) else $error("mclk ratio wrong");
	a_word_width: assert property (serial_setting.bclk_fs == 7'h40 && serial_setting.word_bits
		== (serial_setting.format == FMT_RIGHT_20 ? 5'h14 : serial_setting.format == FMT_RIGHT_18
		? 5'h12 : serial_setting.format == FMT_RIGHT_16 ? 5'h10 : 5'h18))
		else $error("word width wrong");
	a_ack_hold: assert property (scl && $past(scl) && $past(scl, 2) |-> $stable(sda_oe))
		else $error("sda drive changed while scl high");
	a_ack_in_low: assert property ($rose(sda_oe) |-> !scl && !$past(scl))
		else $error("sda drive rose outside scl low");
endmodule
bind amp_serial_config_registers amp_cfg_checker i_checker (.clk, .rst_n, .scl, .sda_oe,
	.combined_mode, .format_strap0, .format_strap1, .format_strap2, .clock_ratio_strap,
	.rate_band_strap, .pin_ratio_code, .pin_band_code, .rate_mismatch, .serial_setting,
	.left_ctrl, .right_ctrl, .modulator, .left_out_en, .right_out_en);
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import amp_pkg::*;
	localparam logic [6:0] DEV = 7'h6C;
	logic            clk, rst_n, scl, host_sda, sda_oe, sda_out, cm, rm, cs, rs, loe, roe;
	logic [2:0]      straps;
	logic [1:0]      prc, pbc;
	logic [7:0]      last;
	serial_setting_t ss;
	chan_ctrl_t      lc, rc;
	misc_t           md;
	int              mismatches, checks;
	logic [31:0]     seed = 32'h200CE41D;
	logic [7:0]      regs [4] = '{8'h10, 8'h20, 8'h21, 8'h30};
	logic [7:0]      defs [4] = '{8'h08, 8'h00, 8'h00, 8'h03};
	wire logic       sda_line = (sda_oe ? sda_out : 1'b1) & host_sda;
	i2c_host_model i_host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda(host_sda));
	amp_serial_config_registers i_dut (.clk(clk), .rst_n(rst_n), .scl(scl),
		.sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .combined_mode(cm),
		.format_strap0(straps[0]), .format_strap1(straps[1]), .format_strap2(straps[2]),
		.clock_ratio_strap(cs), .rate_band_strap(rs), .pin_ratio_code(prc),
		.pin_band_code(pbc), .rate_mismatch(rm), .serial_setting(ss), .left_ctrl(lc),
		.right_ctrl(rc), .modulator(md), .left_out_en(loe), .right_out_en(roe),
		.last_access(last));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	function automatic logic [31:0] rnd();
		seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h0);
		return seed;
	endfunction
	function automatic logic [9:0] mfs(input logic [1:0] b, input logic [1:0] r);
		logic [9:0] v;
		v = r[0] ? 10'h180 : 10'h100;
		if (r[1]) v = v << 1;
		return v >> (b[1] ? 2'(b[0]) + 2'h1 : 2'h0);
	endfunction
	// fixed and reserved bits never take the written value
	function automatic logic [7:0] masked(input logic [7:0] r, input logic [7:0] d);
		case (r)
			8'h10: return d & 8'h7F;
			8'h30: return (d & 8'h0E) | 8'h01;
			default: return d;
		endcase
	endfunction
	task automatic wr(input logic [7:0] r, input logic [7:0] d);
		logic n;
		i_host.start();
		i_host.put({DEV, 1'b0}, n);
		i_host.put(r, n);
		i_host.put(d, n);
		check(n, 1'b0);
		i_host.stop();
	endtask
	task automatic rd(input logic [7:0] r, output logic [7:0] d);
		logic n;
		i_host.start();
		i_host.put({DEV, 1'b0}, n);
		i_host.put(r, n);
		i_host.start();
		i_host.put({DEV, 1'b1}, n);
		i_host.get(1'b1, d);
		i_host.stop();
	endtask
	task automatic check_defaults();
		logic [7:0] v;
		for (int i = 0; i < 4; i++) begin
			rd(regs[i], v);
			check(v, defs[i]);
		end
		check(md, 8'h03);
	endtask
	task automatic check_setting(input logic [7:0] c);
		logic [2:0] f;
		logic [1:0] b, r;
		logic [4:0] w;
		f = (cm && straps == 3'h0) ? c[2:0] : straps;
		b = (cm && !rs) ? c[4:3] : pbc;
		r = (cm && !cs) ? c[6:5] : prc;
		w = f == 3'h4 ? 5'h14 : f == 3'h5 ? 5'h12 : f == 3'h6 ? 5'h10 : 5'h18;
		check(ss.format, f);
		check(ss.band, b);
		check(ss.ratio, r);
		check(ss.word_bits, w);
		check(ss.mclk_fs, mfs(b, r));
		check(ss.bclk_fs, 7'h40);
	endtask
	initial begin
		logic [7:0] r, d, v;
		logic [31:0] x;
		logic n;
		rst_n = 1'b0;
		{cm, rm, cs, rs, straps, prc, pbc} = 11'h400;
		repeat (20) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		check(last, 8'h00);
		check(sda_oe, 1'b0);
		check(sda_out, 1'b0);
		check_defaults();
		check_setting(8'h08);
		// bus speed varies so slow and prompt hosts are both exercised
		for (int k = 0; k < 16; k++) begin
			x = rnd();
			r = regs[x[9:8]];
			d = x[7:0];
			rm = x[10];
			i_host.half = x[11] ? 4 : 2;
			wr(r, d);
			rd(r, v);
			check(v, masked(r, d));
			check(last, r);
			rd(8'h00, v);
			check(v, r);
			if (r == 8'h20) check(lc, d);
			if (r == 8'h21) check(rc, d);
			if (r == 8'h20) check(loe, !d[7] && !rm);
			if (r == 8'h21) check(roe, !d[7] && !rm);
		end
		wr(8'h20, 8'h00);
		wr(8'h21, 8'h00);
		for (int k = 0; k < 16; k++) begin
			x = rnd();
			d = {x[7:3], 3'(k)};
			cm = k < 8 || x[8];
			straps = k < 8 ? 3'h0 : x[11:9];
			{cs, rs, prc, pbc} = x[17:12];
			wr(8'h10, d);
			check_setting(d);
		end
		rd(8'h20, d);
		wr(8'h00, 8'hA5);
		wr(8'h55, 8'h5A);
		wr(8'hFF, 8'h12);
		rd(8'h20, v);
		check(v, d);
		rd(8'h55, v);
		check(v, 8'h00);
		i_host.start();
		i_host.put({DEV ^ 7'h01, 1'b0}, n);
		i_host.stop();
		check(n, 1'b1);
		wr(8'hFF, 8'hFF);
		check(last, 8'hFF);
		check_defaults();
		rd(8'hFF, v);
		check(v, 8'h00);
		wr(8'h30, 8'h0F);
		rst_n = 1'b0;
		repeat (3) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		check_defaults();
		print_verdict();
	end
endmodule
`default_nettype wire
